// ===== kbi_checker.sv
// Purpose: port checks; Assumes: one clock, sync reset; Notes: bound below
`timescale 1ns/10ps
module kbi_checker (
  input wire ref_clk, rst, sfr_wr, sfr_rd, sfr_hit, power_down,
  input wire [7:0] sfr_addr, sfr_rdata,
  input wire global_key_irq_enable, key_priority_high, key_priority_low,
  input wire combined_key_request, key_irq, key_wake, key_wake_async,
  input wire [1:0] key_irq_priority
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_irq_gated: assert property (key_irq == (combined_key_request &&
    $past(global_key_irq_enable))) else $error("gate");
  a_prio_map: assert property (!$past(rst) |-> key_irq_priority ==
    {$past(key_priority_high), $past(key_priority_low)}) else $error("prio");
  a_flag_kept: assert property (!$past(rst) &&
    $fell(combined_key_request) |-> $past(sfr_wr)) else $error("drop");
  a_hit_mapped: assert property (sfr_hit |-> $past(sfr_rd) &&
    $past(sfr_addr) inside {8'h9c, 8'h9d, 8'h9e}) else $error("hit");
  a_read_hit: assert property (sfr_rd && sfr_addr == 8'h9e |=>
    sfr_hit) else $error("miss");
  a_rdata_zero: assert property (!sfr_hit |-> sfr_rdata == 8'h00)
    else $error("rdata");
  a_wake_pd: assert property (key_wake_async |-> power_down)
    else $error("pd");
  a_wake_req: assert property ($rose(combined_key_request) &&
    !$past(sfr_wr) && !$past(sfr_wr, 2) |-> key_wake) else $error("wake");
  c_irq: cover property (key_irq);
  c_wake: cover property (key_wake_async);
  c_hit: cover property (sfr_hit);
endmodule // kbi_checker
bind kbi_keyboard kbi_checker chk_u (.*);

// ===== kbi_defs.vh
// Purpose: Constants for the keyboard level interrupt block
// Assumes: 8-bit special function register bus of the core
// Notes:   Offsets are special function register addresses
`ifndef KBI_DEFS_VH
`define KBI_DEFS_VH

`define KBI_ADDR_LEVEL_SEL   8'h9c
`define KBI_ADDR_LINE_EN     8'h9d
`define KBI_ADDR_LINE_FLAGS  8'h9e
`define KBI_RST_LEVEL_SEL    8'h00
`define KBI_RST_LINE_EN      8'h00
`define KBI_RST_LINE_FLAGS   8'h00
`define KBI_PRIO_LOWEST      2'b00
`define KBI_PRIO_HIGHEST     2'b11

`endif

// ===== kbi_keyboard.v
// Purpose: Eight-line keyboard level interrupt logic on one port
// Assumes: Core special function register access, one clock domain
// Notes:   Flags are level based and set again while level holds
//
// Notes on behaviour
// - Eight independent port inputs share one keyboard request and vector.
// - Level select 0 detects low level, 1 detects high level.
// - Input matching its programmed level sets that line's flag.
// - Hardware never clears flags; software clears them after service.
// - Flag records detection; enable masks flag onto request and level onto wake.
// - Enable 0 leaves plain I/O pin; enable 1 lets flag request.
// - Global keyboard enable in second enable register gates key_irq, not the combined request.
// - Level detection wakes the core from idle and power-down.
// - Exactly three registers: level select, line enable, line flags.
// - All three registers reset to zero: plain I/O, low detect.
// - Interrupt priority from high and low bits, 00 lowest, 11 highest.
`timescale 1ns/10ps
`include "kbi_defs.vh"

module kbi_keyboard #(
  parameter LINES = 8
) (
  // Clock and reset
  input  wire             ref_clk,
  input  wire             rst,
  // Keyboard port pins
  input  wire [LINES-1:0] keyboard_port,
  // Special function register access
  input  wire [7:0]       sfr_addr,
  input  wire             sfr_wr,
  input  wire             sfr_rd,
  input  wire [7:0]       sfr_wdata,
  output reg  [7:0]       sfr_rdata,
  output reg              sfr_hit,
  // Interrupt system bits kept in the core's own registers
  input  wire             global_key_irq_enable,
  input  wire             key_priority_high,
  input  wire             key_priority_low,
  // Power management
  input  wire             power_down,
  // Status and requests
  output reg              combined_key_request,
  output reg              key_irq,
  output reg  [1:0]       key_irq_priority,
  output reg              key_wake,
  output wire             key_wake_async
);

  reg  [LINES-1:0] key_level_select_q;
  reg  [LINES-1:0] key_line_enable_q;
  reg  [LINES-1:0] key_line_flags_q;
  reg  [LINES-1:0] flags_d;
  wire [LINES-1:0] port_sync;
  wire [LINES-1:0] level_hit;
  wire [LINES-1:0] level_hit_raw;

  kbi_sync #(
    .WIDTH (LINES)
  ) u_sync (
    .ref_clk (ref_clk),
    .rst     (rst),
    .din     (keyboard_port),
    .dout    (port_sync)
  );

  // Match: xnor of pin and select
  function [LINES-1:0] match;
    input [LINES-1:0] pins;
    input [LINES-1:0] sel;
    begin
      match = ~(pins ^ sel);
    end
  endfunction

  function is_addr;
    input [7:0] a;
    input [7:0] ref_a;
    begin
      is_addr = (a == ref_a);
    end
  endfunction

  assign level_hit = match(port_sync, key_level_select_q);

  // Clock is frozen in power-down, so wake must bypass flops
  assign level_hit_raw = match(keyboard_port, key_level_select_q);
  assign key_wake_async = power_down &
                          (|(level_hit_raw & key_line_enable_q));

  // Set wins over software clear so no detection is lost
  always @* begin
    flags_d = key_line_flags_q;
    if (sfr_wr && is_addr(sfr_addr, `KBI_ADDR_LINE_FLAGS)) begin
      flags_d = sfr_wdata[LINES-1:0];
    end
    flags_d = flags_d | level_hit;
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      key_level_select_q <= `KBI_RST_LEVEL_SEL;
      key_line_enable_q  <= `KBI_RST_LINE_EN;
      key_line_flags_q   <= `KBI_RST_LINE_FLAGS;
    end else begin
      if (sfr_wr && is_addr(sfr_addr, `KBI_ADDR_LEVEL_SEL)) begin
        key_level_select_q <= sfr_wdata[LINES-1:0];
      end
      if (sfr_wr && is_addr(sfr_addr, `KBI_ADDR_LINE_EN)) begin
        key_line_enable_q <= sfr_wdata[LINES-1:0];
      end
      key_line_flags_q <= flags_d;
    end
  end

  // Registered read port and request outputs
  always @(posedge ref_clk) begin
    if (rst) begin
      sfr_rdata            <= 8'h00;
      sfr_hit              <= 1'b0;
      combined_key_request <= 1'b0;
      key_irq              <= 1'b0;
      key_irq_priority     <= `KBI_PRIO_LOWEST;
      key_wake             <= 1'b0;
    end else begin
      sfr_hit   <= 1'b0;
      sfr_rdata <= 8'h00;
      if (sfr_rd) begin
        if (is_addr(sfr_addr, `KBI_ADDR_LEVEL_SEL)) begin
          sfr_rdata <= key_level_select_q;
          sfr_hit   <= 1'b1;
        end else if (is_addr(sfr_addr, `KBI_ADDR_LINE_EN)) begin
          sfr_rdata <= key_line_enable_q;
          sfr_hit   <= 1'b1;
        end else if (is_addr(sfr_addr, `KBI_ADDR_LINE_FLAGS)) begin
          sfr_rdata <= key_line_flags_q;
          sfr_hit   <= 1'b1;
        end
      end
      combined_key_request <= |(flags_d & key_line_enable_q);
      key_irq <= global_key_irq_enable &
                 (|(flags_d & key_line_enable_q));
      key_irq_priority <= {key_priority_high, key_priority_low};
      key_wake <= |(level_hit & key_line_enable_q);
    end
  end

endmodule // kbi_keyboard

// ===== kbi_keypad.sv
// Purpose: keypad with pull-ups; Assumes: key pulls low; Notes: idle high
`timescale 1ns/10ps
module kbi_keypad (input wire [7:0] press, output wire [7:0] keyboard_port);
  // Released lines rest at the pull-up level, never hold a stale value
  assign keyboard_port = ~press;
endmodule // kbi_keypad

// ===== kbi_sync.v
// Purpose: Two-flop synchroniser for a vector of port inputs
// Assumes: Single clock, synchronous active-high reset
// Notes:   First stage feeds only the second stage
`timescale 1ns/10ps

module kbi_sync #(
  parameter WIDTH = 8
) (
  // Clock and reset
  input  wire             ref_clk,
  input  wire             rst,
  // Data
  input  wire [WIDTH-1:0] din,
  output wire [WIDTH-1:0] dout
);

  reg [WIDTH-1:0] meta_q;
  reg [WIDTH-1:0] sync_q;

  always @(posedge ref_clk) begin
    if (rst) begin
      // Reset to pull-up idle level, so low detect sees no false hit
      meta_q <= {WIDTH{1'b1}};
      sync_q <= {WIDTH{1'b1}};
    end else begin
      meta_q <= din;
      sync_q <= meta_q;
    end
  end

  assign dout = sync_q;

endmodule // kbi_sync

// ===== tb_kbi_keyboard.sv
// Purpose: bench; Assumes: pull-up keypad; Notes: fixed latencies, no polls
`timescale 1ns/10ps
module tb_kbi_keyboard;
  reg ref_clk = 0, rst = 1, sfr_wr = 0, sfr_rd = 0, power_down = 0;
  reg global_key_irq_enable = 0, key_priority_high = 0, key_priority_low = 0;
  reg [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, press = 8'h00;
  wire [7:0] keyboard_port, sfr_rdata;
  wire [1:0] key_irq_priority;
  wire sfr_hit, combined_key_request, key_irq, key_wake, key_wake_async;
  integer failures = 0, checked = 0, i;
  initial forever #10 ref_clk = ~ref_clk;
  kbi_keypad pad_u (.*);
  kbi_keyboard dut_u (.*);
  task cyc(input integer n); repeat (n) @(posedge ref_clk); #1; endtask
  task chk(input [7:0] g, e);
    checked = checked + 1;
    if (g !== e) begin
      failures = failures + 1;
      $display("ERROR %0t got %h exp %h", $time, g, e);
    end
  endtask
  task wr(input [7:0] a, d);
    {sfr_addr, sfr_wdata, sfr_wr} = {a, d, 1'b1};
    cyc(1);
    sfr_wr = 0;
    cyc(1);
  endtask
  task rd(input [7:0] a, e);
    {sfr_addr, sfr_rd} = {a, 1'b1};
    cyc(1);
    sfr_rd = 0;
    chk(sfr_rdata, e);
    chk({7'h00, sfr_hit}, {7'h00, (a >= 8'h9c) && (a <= 8'h9e)});
    cyc(1);
  endtask
  task end_of_test;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    cyc(3);
    rst = 0;
    rd(8'h9c, 8'h00);
    rd(8'h9d, 8'h00);
    rd(8'h9e, 8'h00);
    rd(8'h9f, 8'h00);
    wr(8'h9e, 8'h00);
    rd(8'h9e, 8'h00);
    press = 8'h08;
    cyc(4);
    rd(8'h9e, 8'h08);
    chk({7'h00, combined_key_request}, 8'h00);
    global_key_irq_enable = 1;
    wr(8'h9d, 8'h08);
    cyc(2);
    chk({7'h00, key_irq}, 8'h01);
    global_key_irq_enable = 0;
    cyc(2);
    chk({7'h00, key_irq}, 8'h00);
    wr(8'h9e, 8'h00);
    rd(8'h9e, 8'h08);
    press = 8'h00;
    cyc(4);
    rd(8'h9e, 8'h08);
    wr(8'h9e, 8'h00);
    rd(8'h9e, 8'h00);
    wr(8'h9d, 8'h80);
    wr(8'h9c, 8'h80);
    power_down = 1;
    cyc(4);
    rd(8'h9e, 8'h80);
    chk({6'h00, key_wake, key_wake_async}, 8'h03);
    for (i = 0; i < 4; i = i + 1) begin
      {key_priority_high, key_priority_low} = i[1:0];
      cyc(2);
      chk({6'h00, key_irq_priority}, i[7:0]);
    end
    end_of_test;
  end
endmodule // tb_kbi_keyboard
